// ### rtl/fci_host.sv
`timescale 1ns/1ps
`include "fci_map.svh"

module fci_host
  import fci_pkg::*;
#(
  parameter int AW = 24
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   sys_rst_i,
  // Command request
  input  wire logic                   cmd_valid_i,
  input  wire fci_op_t                cmd_op_i,
  input  wire logic [AW-1:0]          cmd_addr_i,
  input  wire logic [`FCI_DQ_W-1:0]   cmd_data_i,
  input  wire logic [`FCI_COUNT_W:0]  cmd_count_i,
  output logic                        cmd_ready_o,
  // Buffer data stream
  input  wire logic                   wdata_valid_i,
  input  wire logic [`FCI_DQ_W-1:0]   wdata_i,
  output logic                        wdata_ready_o,
  // Completion
  output logic                        done_o,
  output logic [`FCI_DQ_W-1:0]        rdata_o,
  // Flash pins
  output logic [AW-1:0]               flash_addr_o,
  output logic [`FCI_DQ_W-1:0]        flash_dq_o,
  output logic                        flash_dq_oe_o,
  input  wire logic [`FCI_DQ_W-1:0]   flash_dq_i,
  output logic                        flash_ce_n_o,
  output logic                        flash_oe_n_o,
  output logic                        flash_we_n_o,
  output logic                        flash_adv_n_o,
  output logic                        flash_rst_n_o
);

  localparam int RST_CYC =
    (`FCI_T_RST_LOW_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS;
  localparam int WAKE_CYC =
    (`FCI_T_WAKE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS;
  localparam logic [7:0] RST_LAST  = 8'(RST_CYC - 1);
  localparam logic [7:0] WAKE_LAST = 8'(WAKE_CYC - 1);

  typedef struct packed {
    fci_state_t                st;
    fci_op_t                   op;
    logic [AW-1:0]             addr;
    logic [`FCI_DQ_W-1:0]      data;
    logic [`FCI_COUNT_W:0]     left;
    logic [7:0]                timer;
    logic                      pend;
    logic                      start;
    logic                      wr;
    logic [AW-1:0]             cyc_addr;
    logic [`FCI_DQ_W-1:0]      cyc_data;
    logic                      ready;
    logic                      wready;
    logic                      done;
    logic [`FCI_DQ_W-1:0]      rdata;
    logic                      rst_n;
  } fci_host_t;

  fci_host_t cur;
  fci_host_t next_cur;
  logic                  cyc_done;
  logic [`FCI_DQ_W-1:0]  cyc_rdata;

  // First-cycle command code of each operation
  function automatic logic [`FCI_CODE_W-1:0] first_code(input fci_op_t op);
    case (op)
      FCI_OP_READ_ARRAY:  first_code = `FCI_CODE_READ_ARRAY;
      FCI_OP_READ_STATUS: first_code = `FCI_CODE_READ_STATUS;
      FCI_OP_READ_IDENT:  first_code = `FCI_CODE_READ_IDENT;
      FCI_OP_READ_QUERY:  first_code = `FCI_CODE_READ_QUERY;
      FCI_OP_CLR_STATUS:  first_code = `FCI_CODE_CLR_STATUS;
      FCI_OP_WORD_PROG:   first_code = `FCI_CODE_WORD_PROG;
      FCI_OP_BUF_PROG:    first_code = `FCI_CODE_BUF_PROG;
      FCI_OP_FACTORY:     first_code = `FCI_CODE_FACTORY;
      FCI_OP_ERASE:       first_code = `FCI_CODE_ERASE;
      FCI_OP_SUSPEND:     first_code = `FCI_CODE_SUSPEND;
      FCI_OP_RESUME:      first_code = `FCI_CODE_RESUME;
      FCI_OP_PROT_PROG:   first_code = `FCI_CODE_PROT_PROG;
      default:            first_code = `FCI_CODE_LOCK_SETUP;
    endcase
  endfunction

  // Operations that end after their first write
  function automatic logic single_cycle(input fci_op_t op);
    case (op)
      FCI_OP_READ_ARRAY, FCI_OP_READ_STATUS, FCI_OP_READ_IDENT,
      FCI_OP_READ_QUERY, FCI_OP_CLR_STATUS, FCI_OP_SUSPEND,
      FCI_OP_RESUME:      single_cycle = 1'b1;
      default:            single_cycle = 1'b0;
    endcase
  endfunction

  // Second-cycle data word of each two-cycle operation
  function automatic logic [`FCI_DQ_W-1:0] second_word(
    input fci_op_t               op,
    input logic [`FCI_DQ_W-1:0]  data,
    input logic [`FCI_COUNT_W:0] left
  );
    case (op)
      FCI_OP_BUF_PROG:  second_word = `FCI_DQ_W'(left - 1'b1);
      FCI_OP_FACTORY:   second_word = {8'h00, `FCI_CODE_CONFIRM};
      FCI_OP_ERASE:     second_word = {8'h00, `FCI_CODE_CONFIRM};
      FCI_OP_LOCK:      second_word = {8'h00, `FCI_CODE_LOCK};
      FCI_OP_UNLOCK:    second_word = {8'h00, `FCI_CODE_UNLOCK};
      FCI_OP_LOCKDOWN:  second_word = {8'h00, `FCI_CODE_LOCKDOWN};
      FCI_OP_CFG_SET:   second_word = {8'h00, `FCI_CODE_CFG_SET};
      default:          second_word = data;
    endcase
  endfunction

  // Operation sequencer; each cycle is issued once and awaited
  always_comb begin
    next_cur = cur;
    next_cur.start = 1'b0;
    next_cur.done = 1'b0;
    case (cur.st)
      FCI_S_IDLE: begin
        if (cmd_valid_i && cur.ready) begin
          next_cur.op = cmd_op_i;
          next_cur.addr = cmd_addr_i;
          next_cur.data = cmd_data_i;
          next_cur.left = cmd_count_i;
          next_cur.ready = 1'b0;
          if (cmd_op_i == FCI_OP_RESET) begin
            next_cur.st = FCI_S_RST;
            next_cur.rst_n = 1'b0;
            next_cur.timer = 8'h00;
          end else if (cmd_op_i == FCI_OP_READ) begin
            next_cur.st = FCI_S_READ;
          end else begin
            next_cur.st = FCI_S_FIRST;
          end
        end
      end
      FCI_S_FIRST: begin
        if (!cur.pend) begin
          next_cur.start = 1'b1;
          next_cur.pend = 1'b1;
          next_cur.wr = 1'b1;
          next_cur.cyc_addr = cur.addr;
          next_cur.cyc_data = {8'h00, first_code(cur.op)};
          if (cur.op == FCI_OP_CFG_SET) begin
            next_cur.cyc_addr = AW'(cur.data);
          end
        end else if (cyc_done) begin
          next_cur.pend = 1'b0;
          if (single_cycle(cur.op)) begin
            next_cur.st = FCI_S_IDLE;
            next_cur.done = 1'b1;
            next_cur.ready = 1'b1;
          end else begin
            next_cur.st = FCI_S_SECOND;
          end
        end
      end
      FCI_S_SECOND: begin
        if (!cur.pend) begin
          next_cur.start = 1'b1;
          next_cur.pend = 1'b1;
          next_cur.cyc_data = second_word(cur.op, cur.data, cur.left);
        end else if (cyc_done) begin
          next_cur.pend = 1'b0;
          if (cur.op == FCI_OP_BUF_PROG || cur.op == FCI_OP_FACTORY) begin
            next_cur.st = FCI_S_LOAD;
            next_cur.wready = 1'b1;
          end else begin
            next_cur.st = FCI_S_IDLE;
            next_cur.done = 1'b1;
            next_cur.ready = 1'b1;
          end
        end
      end
      FCI_S_LOAD: begin
        if (cur.wready && wdata_valid_i) begin
          next_cur.wready = 1'b0;
          next_cur.start = 1'b1;
          next_cur.pend = 1'b1;
          next_cur.cyc_data = wdata_i;
        end else if (cur.pend && cyc_done) begin
          next_cur.pend = 1'b0;
          next_cur.left = cur.left - 1'b1;
          next_cur.cyc_addr = cur.cyc_addr + 1'b1;
          if (cur.left == 1) begin
            if (cur.op == FCI_OP_BUF_PROG) begin
              next_cur.st = FCI_S_CONF;
            end else begin
              next_cur.st = FCI_S_IDLE;
              next_cur.done = 1'b1;
              next_cur.ready = 1'b1;
            end
          end else begin
            next_cur.wready = 1'b1;
          end
        end
      end
      FCI_S_CONF: begin
        if (!cur.pend) begin
          next_cur.start = 1'b1;
          next_cur.pend = 1'b1;
          next_cur.cyc_addr = cur.addr;
          next_cur.cyc_data = {8'h00, `FCI_CODE_CONFIRM};
        end else if (cyc_done) begin
          next_cur.pend = 1'b0;
          next_cur.st = FCI_S_IDLE;
          next_cur.done = 1'b1;
          next_cur.ready = 1'b1;
        end
      end
      FCI_S_READ: begin
        if (!cur.pend) begin
          next_cur.start = 1'b1;
          next_cur.pend = 1'b1;
          next_cur.wr = 1'b0;
          next_cur.cyc_addr = cur.addr;
        end else if (cyc_done) begin
          next_cur.pend = 1'b0;
          next_cur.st = FCI_S_IDLE;
          next_cur.rdata = cyc_rdata;
          next_cur.done = 1'b1;
          next_cur.ready = 1'b1;
        end
      end
      FCI_S_RST: begin
        next_cur.timer = cur.timer + 8'h01;
        if (cur.timer == RST_LAST) begin
          next_cur.st = FCI_S_WAKE;
          next_cur.rst_n = 1'b1;
          next_cur.timer = 8'h00;
        end
      end
      FCI_S_WAKE: begin
        next_cur.timer = cur.timer + 8'h01;
        if (cur.timer == WAKE_LAST) begin
          next_cur.st = FCI_S_IDLE;
          next_cur.done = 1'b1;
          next_cur.ready = 1'b1;
        end
      end
      default: begin
        next_cur.st = FCI_S_IDLE;
        next_cur.ready = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur <= '{st: FCI_S_IDLE, op: FCI_OP_READ, ready: 1'b1,
               rst_n: 1'b1, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // Pin-level cycle engine
  fci_bus_cycle #(
    .AW (AW)
  ) u_cycle (
    .clock_i       (clock_i),
    .sys_rst_i     (sys_rst_i),
    .start_i       (cur.start),
    .write_i       (cur.wr),
    .addr_i        (cur.cyc_addr),
    .data_i        (cur.cyc_data),
    .done_o        (cyc_done),
    .rdata_o       (cyc_rdata),
    .flash_addr_o  (flash_addr_o),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o),
    .flash_dq_i    (flash_dq_i),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_oe_n_o  (flash_oe_n_o),
    .flash_we_n_o  (flash_we_n_o),
    .flash_adv_n_o (flash_adv_n_o)
  );

  assign cmd_ready_o   = cur.ready;
  assign wdata_ready_o = cur.wready;
  assign done_o        = cur.done;
  assign rdata_o       = cur.rdata;
  assign flash_rst_n_o = cur.rst_n;

endmodule

// ### rtl/fci_map.svh
`ifndef FCI_MAP_SVH
`define FCI_MAP_SVH

// Command codes carried in the low data byte
`define FCI_CODE_READ_ARRAY  8'hff
`define FCI_CODE_READ_STATUS 8'h70
`define FCI_CODE_READ_IDENT  8'h90
`define FCI_CODE_READ_QUERY  8'h98
`define FCI_CODE_CLR_STATUS  8'h50
`define FCI_CODE_WORD_PROG   8'h40
`define FCI_CODE_WORD_PROG2  8'h10
`define FCI_CODE_BUF_PROG    8'he8
`define FCI_CODE_CONFIRM     8'hd0
`define FCI_CODE_FACTORY     8'h80
`define FCI_CODE_ERASE       8'h20
`define FCI_CODE_SUSPEND     8'hb0
`define FCI_CODE_RESUME      8'hd0
`define FCI_CODE_LOCK_SETUP  8'h60
`define FCI_CODE_LOCK        8'h01
`define FCI_CODE_UNLOCK      8'hd0
`define FCI_CODE_LOCKDOWN    8'h2f
`define FCI_CODE_PROT_PROG   8'hc0
`define FCI_CODE_CFG_SET     8'h03

// Bus geometry
`define FCI_DQ_W             16
`define FCI_CODE_W           8
`define FCI_COUNT_W          6
`define FCI_BUF_MAX          32

// Timing, in ns, and the clock period
`define FCI_CLK_NS           10
`define FCI_T_SETUP_NS       20
`define FCI_T_STROBE_NS      90
`define FCI_T_RST_LOW_NS     100
`define FCI_T_WAKE_NS        150

`endif

// ### rtl/fci_pkg.sv
package fci_pkg;

  // Operations the user side may request
  typedef enum logic [4:0] {
    FCI_OP_READ        = 5'h00,
    FCI_OP_READ_ARRAY  = 5'h01,
    FCI_OP_READ_STATUS = 5'h02,
    FCI_OP_READ_IDENT  = 5'h03,
    FCI_OP_READ_QUERY  = 5'h04,
    FCI_OP_CLR_STATUS  = 5'h05,
    FCI_OP_WORD_PROG   = 5'h06,
    FCI_OP_BUF_PROG    = 5'h07,
    FCI_OP_FACTORY     = 5'h08,
    FCI_OP_ERASE       = 5'h09,
    FCI_OP_SUSPEND     = 5'h0a,
    FCI_OP_RESUME      = 5'h0b,
    FCI_OP_LOCK        = 5'h0c,
    FCI_OP_UNLOCK      = 5'h0d,
    FCI_OP_LOCKDOWN    = 5'h0e,
    FCI_OP_PROT_PROG   = 5'h0f,
    FCI_OP_CFG_SET     = 5'h10,
    FCI_OP_RESET       = 5'h11
  } fci_op_t;

  // Sequencer states of the command controller
  typedef enum logic [7:0] {
    FCI_S_IDLE   = 8'h01,
    FCI_S_FIRST  = 8'h02,
    FCI_S_SECOND = 8'h04,
    FCI_S_LOAD   = 8'h08,
    FCI_S_CONF   = 8'h10,
    FCI_S_READ   = 8'h20,
    FCI_S_RST    = 8'h40,
    FCI_S_WAKE   = 8'h80
  } fci_state_t;

  // Phases of one asynchronous bus cycle
  typedef enum logic [4:0] {
    FCI_B_IDLE   = 5'h01,
    FCI_B_SETUP  = 5'h02,
    FCI_B_STROBE = 5'h04,
    FCI_B_RISE   = 5'h08,
    FCI_B_DONE   = 5'h10
  } fci_phase_t;

endpackage

// ### rtl/fci_bus_cycle.sv
`timescale 1ns/1ps
`include "fci_map.svh"

module fci_bus_cycle
  import fci_pkg::*;
#(
  parameter int AW = 24
) (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 sys_rst_i,
  // Cycle request
  input  wire logic                 start_i,
  input  wire logic                 write_i,
  input  wire logic [AW-1:0]        addr_i,
  input  wire logic [`FCI_DQ_W-1:0] data_i,
  output logic                      done_o,
  output logic [`FCI_DQ_W-1:0]      rdata_o,
  // Flash pins
  output logic [AW-1:0]             flash_addr_o,
  output logic [`FCI_DQ_W-1:0]      flash_dq_o,
  output logic                      flash_dq_oe_o,
  input  wire logic [`FCI_DQ_W-1:0] flash_dq_i,
  output logic                      flash_ce_n_o,
  output logic                      flash_oe_n_o,
  output logic                      flash_we_n_o,
  output logic                      flash_adv_n_o
);

  localparam int SETUP_CYC =
    (`FCI_T_SETUP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS;
  localparam int STROBE_CYC =
    (`FCI_T_STROBE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS;
  localparam logic [7:0] SETUP_LAST  = 8'(SETUP_CYC - 1);
  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

  typedef struct packed {
    fci_phase_t             ph;
    logic [7:0]             cnt;
    logic                   wr;
    logic                   done;
    logic [`FCI_DQ_W-1:0]   rdata;
    logic [`FCI_DQ_W-1:0]   dq_s1;
    logic [`FCI_DQ_W-1:0]   dq_s2;
    logic [AW-1:0]          addr;
    logic [`FCI_DQ_W-1:0]   dq;
    logic                   dq_oe;
    logic                   ce_n;
    logic                   oe_n;
    logic                   we_n;
    logic                   adv_n;
  } fci_cyc_t;

  fci_cyc_t cur;
  fci_cyc_t next_cur;

  // Phase sequencer for one write or read cycle
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.dq_s1 = flash_dq_i;  // Pins come from outside the clock domain
    next_cur.dq_s2 = cur.dq_s1;
    case (cur.ph)
      FCI_B_IDLE: begin
        if (start_i) begin
          next_cur.ph = FCI_B_SETUP;
          next_cur.cnt = 8'h00;
          next_cur.wr = write_i;
          next_cur.addr = addr_i;
          next_cur.dq = data_i;
          next_cur.dq_oe = write_i;
          next_cur.ce_n = 1'b0;
          next_cur.adv_n = 1'b0;
        end
      end
      FCI_B_SETUP: begin
        next_cur.cnt = cur.cnt + 8'h01;
        if (cur.cnt == SETUP_LAST) begin
          next_cur.ph = FCI_B_STROBE;
          next_cur.cnt = 8'h00;
          next_cur.we_n = ~cur.wr;
          next_cur.oe_n = cur.wr;
        end
      end
      FCI_B_STROBE: begin
        next_cur.cnt = cur.cnt + 8'h01;
        if (cur.cnt == STROBE_LAST) begin
          next_cur.ph = FCI_B_RISE;
          next_cur.we_n = 1'b1;
          next_cur.oe_n = 1'b1;
          if (!cur.wr) begin
            next_cur.rdata = cur.dq_s2;
          end
        end
      end
      FCI_B_RISE: begin
        // Chip select held a cycle past the strobe edge, data driven two cycles past it
        next_cur.ph = FCI_B_DONE;
        next_cur.ce_n = 1'b1;
        next_cur.adv_n = 1'b1;
      end
      FCI_B_DONE: begin
        next_cur.ph = FCI_B_IDLE;
        next_cur.dq_oe = 1'b0;
        next_cur.done = 1'b1;
      end
      default: begin
        next_cur.ph = FCI_B_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur <= '{ph: FCI_B_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
               adv_n: 1'b1, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign done_o        = cur.done;
  assign rdata_o       = cur.rdata;
  assign flash_addr_o  = cur.addr;
  assign flash_dq_o    = cur.dq;
  assign flash_dq_oe_o = cur.dq_oe;
  assign flash_ce_n_o  = cur.ce_n;
  assign flash_oe_n_o  = cur.oe_n;
  assign flash_we_n_o  = cur.we_n;
  assign flash_adv_n_o = cur.adv_n;

endmodule

// ### verification/fci_host_sva.sv
`timescale 1ns/1ps
module fci_host_sva #(
  parameter int AW = 24
) (
  // Clock and reset
  input wire logic          clock_i,
  input wire logic          sys_rst_i,
  // Handshakes
  input wire logic          cmd_valid_i,
  input wire logic          cmd_ready_o,
  input wire logic          wdata_valid_i,
  input wire logic          wdata_ready_o,
  input wire logic          done_o,
  // Flash pins
  input wire logic [AW-1:0] flash_addr_o,
  input wire logic [15:0]   flash_dq_o,
  input wire logic          flash_dq_oe_o,
  input wire logic          flash_ce_n_o,
  input wire logic          flash_oe_n_o,
  input wire logic          flash_we_n_o,
  input wire logic          flash_adv_n_o,
  input wire logic          flash_rst_n_o
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_take;
    cmd_valid_i && cmd_ready_o |=> !cmd_ready_o;
  endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_done;
    done_o |-> cmd_ready_o && flash_ce_n_o && !flash_dq_oe_o;
  endproperty
  a_done: assert property (p_done) else $error("done while busy");
  property p_we_ctrl;
    !flash_we_n_o |-> !flash_ce_n_o && !flash_adv_n_o && flash_oe_n_o
                      && flash_dq_oe_o;
  endproperty
  a_we_ctrl: assert property (p_we_ctrl) else $error("bad write pins");
  property p_we_len;
    $fell(flash_we_n_o) |-> !flash_we_n_o[*8] ##[1:2] flash_we_n_o;
  endproperty
  a_we_len: assert property (p_we_len) else $error("strobe length");
  // Address and data must be steady up to the latching edge
  property p_we_hold;
    $rose(flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("moved at edge");
  property p_rd_ctrl;
    !flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("read drives bus");
  property p_rst_len;
    $fell(flash_rst_n_o) |-> !flash_rst_n_o[*8];
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset too short");
  property p_rst_busy;
    !flash_rst_n_o |-> !cmd_ready_o && flash_ce_n_o;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("idle in reset");
  property p_wr_take;
    wdata_valid_i && wdata_ready_o |=> !wdata_ready_o;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("word not taken");
  c_word: cover property (wdata_valid_i && wdata_ready_o);
  c_rst: cover property ($fell(flash_rst_n_o));
  c_read: cover property ($fell(flash_oe_n_o));
endmodule

bind fci_host fci_host_sva #(.AW(AW)) fci_host_sva_inst (
  .clock_i, .sys_rst_i, .cmd_valid_i, .cmd_ready_o, .wdata_valid_i,
  .wdata_ready_o, .done_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o,
  .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_rst_n_o, .flash_adv_n_o
);

// ### verification/fci_flash_model.sv
`timescale 1ns/1ps
module fci_flash_model #(
  parameter int          AW       = 24,
  // Identifier and query words are arbitrary values
  parameter logic [15:0] ID_WORD  = 16'h3a5c,
  parameter logic [15:0] QRY_WORD = 16'h00c3
) (
  // Pins driven by the host
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [15:0]   dq_i,
  input  wire logic          dq_oe_i,
  input  wire logic          ce_n_i,
  input  wire logic          oe_n_i,
  input  wire logic          we_n_i,
  input  wire logic          rst_n_i,
  // Resolved data bus level
  output logic [15:0]        bus_o
);
  logic [15:0]   mem [64];
  logic [AW-1:0] la [512];
  logic [15:0]   ld [512];
  logic [15:0]   rd;
  logic [15:0]   last = 16'h0000;
  logic [7:0]    sr = 8'h80;
  logic [7:0]    pend = 8'h00;
  logic [7:0]    c;
  logic [1:0]    mode = 2'd0;
  int            n = 0;
  int            cnt;

  always @(negedge rst_n_i) begin
    mode = 2'd0;
    sr = 8'h80;
    pend = 8'h00;
  end

  assign rd = mode == 2'd0 ? mem[addr_i[5:0]] : mode == 2'd1 ? {8'h00, sr}
            : mode == 2'd2 ? ID_WORD : QRY_WORD;
  // No pull on the bus, so a released bus must not echo old data
  always @(posedge oe_n_i) last = rd;
  assign bus_o = dq_oe_i ? dq_i
               : (!oe_n_i && !ce_n_i && rst_n_i) ? rd : ~last;

  always @(posedge we_n_i or posedge ce_n_i) begin
    if ((we_n_i ^ ce_n_i) && rst_n_i) begin
      la[n] = addr_i;
      ld[n] = dq_i;
      n++;
      c = dq_i[7:0];
      // programs end at once, so no command meets a busy span
      if (pend == 8'h40) begin
        mem[addr_i[5:0]] = dq_i;
        pend = 8'h00;
      end else if (pend == 8'h20) begin
        if (c != 8'hd0) sr[5:4] = 2'b11;
        pend = 8'h00;
      end else if (pend == 8'he8) begin
        cnt = int'(dq_i) + 1;
        pend = 8'he9;
      end else if (pend == 8'he9 && cnt > 0) begin
        mem[addr_i[5:0]] = dq_i;
        cnt--;
      end else if (pend == 8'h80 && c == 8'hd0) pend = 8'h81;
      else if (pend == 8'h81) mem[addr_i[5:0]] = dq_i;
      else if (pend != 8'h00) pend = 8'h00;
      else begin
        case (c)
          8'hff: mode = 2'd0;
          8'h70, 8'hb0, 8'hd0: mode = 2'd1;
          8'h90: mode = 2'd2;
          8'h98: mode = 2'd3;
          8'h50: sr[5:1] = 5'h00;
          8'h10: pend = 8'h40;
          default: pend = c;
        endcase
        if (pend != 8'h00) mode = 2'd1;
      end
    end
  end
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fci_pkg::*;
  // Arbitrary identifier and query words
  localparam logic [15:0] ID_W = 16'h3a5c;
  localparam logic [15:0] QRY_W = 16'h00c3;
  // Stimulus, driven on the falling edge
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cmd_valid_i = 1'b0;
  fci_op_t     cmd_op_i = FCI_OP_READ;
  logic [23:0] cmd_addr_i = 24'h000000;
  logic [15:0] cmd_data_i = 16'h0000;
  logic [6:0]  cmd_count_i = 7'h00;
  logic        wdata_valid_i = 1'b0;
  logic [15:0] wdata_i = 16'h0000;
  // Design outputs and the resolved bus
  logic        cmd_ready_o, wdata_ready_o, done_o, flash_dq_oe_o;
  logic        flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_adv_n_o;
  logic        flash_rst_n_o;
  logic [23:0] flash_addr_o;
  logic [15:0] rdata_o, flash_dq_o, dq_bus;
  int          error_cnt = 0;
  int          checked = 0;

  fci_host #(.AW(24)) fci_host_inst (
    .clock_i, .sys_rst_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_data_i,
    .cmd_count_i, .cmd_ready_o, .wdata_valid_i, .wdata_i, .wdata_ready_o,
    .done_o, .rdata_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o,
    .flash_dq_i(dq_bus), .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o,
    .flash_adv_n_o, .flash_rst_n_o
  );
  fci_flash_model #(.AW(24), .ID_WORD(ID_W), .QRY_WORD(QRY_W))
    fci_flash_model_inst (
    .addr_i(flash_addr_o), .dq_i(flash_dq_o), .dq_oe_i(flash_dq_oe_o),
    .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .rst_n_i(flash_rst_n_o), .bus_o(dq_bus)
  );

  // 100 MHz clock
  initial forever #5 clock_i = ~clock_i;

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Write k of the device log against address and word
  task automatic expw(input int k, input logic [23:0] a,
                      input logic [15:0] d);
    chk(fci_flash_model_inst.la[k], a);
    chk({8'h00, fci_flash_model_inst.ld[k]}, {8'h00, d});
  endtask

  // Waiting for ready at a falling edge means the next rise takes it
  task automatic issue(input fci_op_t op, input logic [23:0] a,
                       input logic [15:0] d, input logic [6:0] c);
    int t;
    t = 0;
    @(negedge clock_i);
    while (cmd_ready_o !== 1'b1 && t < 5000) begin
      @(negedge clock_i);
      t++;
    end
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_count_i = c;
    cmd_valid_i = 1'b1;
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && t < 5000) begin
      @(negedge clock_i);
      t++;
    end
    if (t == 5000) chk(24'h000000, 24'h000001);
  endtask

  // Stream words with stalls of 0 to 3 cycles, repeating, between them
  task automatic stream(input int n, input logic [15:0] base);
    int t;
    for (int i = 0; i < n; i++) begin
      t = 0;
      repeat (i % 4) @(negedge clock_i);
      @(negedge clock_i);
      while (wdata_ready_o !== 1'b1 && t < 5000) begin
        @(negedge clock_i);
        t++;
      end
      wdata_i = base + 16'(i);
      wdata_valid_i = 1'b1;
      @(negedge clock_i);
      wdata_valid_i = 1'b0;
    end
  endtask

  task automatic t_reads();
    int k;
    fci_op_t rop [4] = '{FCI_OP_READ_ARRAY, FCI_OP_READ_IDENT,
                        FCI_OP_READ_QUERY, FCI_OP_READ_STATUS};
    logic [23:0] rexp [4] = '{24'h00beef, {8'h00, ID_W}, {8'h00, QRY_W},
                             24'h000080};
    issue(FCI_OP_WORD_PROG, 24'h000005, 16'hbeef, 7'h00);
    k = fci_flash_model_inst.n;
    issue(FCI_OP_READ, 24'h000005, 16'h0000, 7'h00);
    chk(24'(fci_flash_model_inst.n - k), 24'h000000);
    chk(rdata_o, 24'h000080);
    for (int i = 0; i < 4; i++) begin
      issue(rop[i], 24'h000100, 16'h0000, 7'h00);
      issue(FCI_OP_READ, 24'h000005, 16'h0000, 7'h00);
      chk(rdata_o, rexp[i]);
    end
    issue(FCI_OP_RESET, 24'h000000, 16'h0000, 7'h00);
    issue(FCI_OP_READ, 24'h000005, 16'h0000, 7'h00);
    chk(rdata_o, 24'h00beef);
  endtask

  task automatic t_one();
    int k;
    fci_op_t op [7] = '{FCI_OP_READ_ARRAY, FCI_OP_READ_STATUS,
                       FCI_OP_READ_IDENT, FCI_OP_READ_QUERY,
                       FCI_OP_CLR_STATUS, FCI_OP_SUSPEND, FCI_OP_RESUME};
    logic [15:0] code [7] = '{16'h00ff, 16'h0070, 16'h0090, 16'h0098,
                             16'h0050, 16'h00b0, 16'h00d0};
    for (int i = 0; i < 7; i++) begin
      k = fci_flash_model_inst.n;
      issue(op[i], 24'h000100 + 24'(i), 16'hffff, 7'h00);
      chk(24'(fci_flash_model_inst.n - k), 24'h000001);
      expw(k, 24'h000100 + 24'(i), code[i]);
    end
  endtask

  task automatic t_two();
    int k;
    logic [23:0] a;
    fci_op_t op [6] = '{FCI_OP_WORD_PROG, FCI_OP_ERASE, FCI_OP_LOCK,
                       FCI_OP_UNLOCK, FCI_OP_LOCKDOWN, FCI_OP_PROT_PROG};
    logic [15:0] c1 [6] = '{16'h0040, 16'h0020, 16'h0060, 16'h0060,
                           16'h0060, 16'h00c0};
    logic [15:0] c2 [6] = '{16'h1234, 16'h00d0, 16'h0001, 16'h00d0,
                           16'h002f, 16'h4321};
    for (int i = 0; i < 6; i++) begin
      k = fci_flash_model_inst.n;
      a = 24'h000300 + 24'(i);
      issue(op[i], a, c2[i], 7'h00);
      expw(k, a, c1[i]);
      expw(k + 1, a, c2[i]);
    end
    k = fci_flash_model_inst.n;
    issue(FCI_OP_CFG_SET, 24'h00aaaa, 16'h1357, 7'h00);
    expw(k, 24'h001357, 16'h0060);
    expw(k + 1, 24'h001357, 16'h0003);
  endtask

  task automatic t_buf(input int n, input bit fac);
    int k;
    logic [23:0] a;
    k = fci_flash_model_inst.n;
    a = 24'h000400;
    fork
      issue(fac ? FCI_OP_FACTORY : FCI_OP_BUF_PROG, a, 16'h0000, 7'(n));
      stream(n, 16'h7700);
    join
    chk(24'(fci_flash_model_inst.n - k), 24'(n + 3 - fac));
    expw(k, a, fac ? 16'h0080 : 16'h00e8);
    expw(k + 1, a, fac ? 16'h00d0 : 16'(n - 1));
    for (int i = 0; i < n; i++)
      expw(k + 2 + i, a + 24'(i), 16'h7700 + 16'(i));
    if (!fac) expw(k + 2 + n, a, 16'h00d0);
    else issue(FCI_OP_RESET, 24'h000000, 16'h0000, 7'h00);
  endtask

  // Reset for 16 cycles, then each scenario in turn
  initial begin
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    sys_rst_i = 1'b0;
    t_reads();
    t_one();
    t_two();
    t_buf(1, 1'b0);
    t_buf(32, 1'b0);
    t_buf(3, 1'b1);
    test_done();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    #300000;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    test_done();
  end
endmodule
